// ===== ioc_pkg.sv
// Function
// - code 000 enters or leaves maintenance mode
// - code 001 takes one word from storage
// - code 010 delivers one word to storage
// - code 011 returns highest level status word
// - code 100 modifier/address as control action
// - code 101 starts channel write operation
// - code 110 starts channel read operation
// - code 111 presents indicator status to accumulator
// - area zero sense picks console or timer
// - data and sense functions overwrite accumulator
// - modifier extends function or selects unit
// - program control ends after single function
// - channel operation ends at table end
// - interrupt on end, error, operator action
// - interrupt conditions held until reset sense
// - sixteen-bit status, interrupt and plain indicators
// - command holds address, area, function, modifier
// - busy ignores execute, not ready ignores all but sense and level
// - sense ignores address, one cycle answer
package ioc_pkg;

	// ****************************************
	// command fields
	// ****************************************
	localparam int IOC_AREA_W = 5;
	localparam int IOC_FUNC_W = 3;
	localparam int IOC_MOD_W  = 8;
	localparam int IOC_WORD_W = 16;
	// bit 7 of command word two, the top modifier bit, is modifier bit 7 here
	localparam int IOC_MOD_RESET_BIT = 7;
	// console area
	localparam logic [4:0] IOC_AREA_CONSOLE = 5'h00;
	// unit code in modifier selecting the interval timer status
	localparam logic [7:0] IOC_UNIT_TIMER = 8'h01;

	// ****************************************
	// status word layout
	// ****************************************
	localparam int IOC_ST_DONE   = 0;  // operation complete, interrupting
	localparam int IOC_ST_ERROR  = 1;  // error, interrupting
	localparam int IOC_ST_OPER   = 2;  // operator intervention, interrupting
	localparam int IOC_ST_MAINT  = 13; // maintenance mode, plain
	localparam int IOC_ST_NRDY   = 14; // not ready, plain
	localparam int IOC_ST_BUSY   = 15; // busy, plain
	localparam logic [15:0] IOC_STATUS_RESET = 16'h0000;

	// ****************************************
	// function codes
	// ****************************************
	typedef enum logic [2:0] {
		IOC_F_MAINT   = 3'h0,
		IOC_F_WRITE   = 3'h1,
		IOC_F_READ    = 3'h2,
		IOC_F_LEVEL   = 3'h3,
		IOC_F_CONTROL = 3'h4,
		IOC_F_CH_WR   = 3'h5,
		IOC_F_CH_RD   = 3'h6,
		IOC_F_SENSE   = 3'h7
	} ioc_func_t;

	// ****************************************
	// operation states
	// ****************************************
	typedef enum logic [3:0] {
		IOC_S_IDLE = 4'h1,
		IOC_S_PROG = 4'h2,
		IOC_S_CHAN = 4'h4,
		IOC_S_DONE = 4'h8
	} ioc_state_t;

endpackage

// ===== ioc_cmd_if.sv
`timescale 1ns/100ps
// decoded command passed from decoder to sequencer
interface ioc_cmd_if;
	import ioc_pkg::*;
	logic             go;       // one-cycle accepted command
	ioc_func_t        func;     // function code
	logic [7:0]       modifier; // modifier field
	logic [15:0]      address;  // address field
	logic             mine;     // area matches own code
	modport dec (output go, func, modifier, address, mine);
	modport seq (input go, func, modifier, address, mine);
endinterface

// ===== ioc_decode.sv
`timescale 1ns/100ps
// splits the two command words and checks the area
module ioc_decode
	import ioc_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// command in
	input  wire logic        cmd_valid,
	input  wire logic [15:0] cmd_word0,
	input  wire logic [15:0] cmd_word1,
	input  wire logic [4:0]  own_area,
	// decoded out
	ioc_cmd_if.dec           cmd
);
	typedef struct packed {
		logic        go;
		ioc_func_t   func;
		logic [7:0]  modifier;
		logic [15:0] address;
		logic        mine;
	} ioc_dec_t;

	ioc_dec_t st;      // registered state
	ioc_dec_t next_st; // next state

	// field split of word two: area, function, modifier
	always_comb begin
		next_st          = st;
		next_st.go       = cmd_valid;
		next_st.address  = cmd_word0;
		next_st.func     = ioc_func_t'(cmd_word1[10:8]);
		next_st.modifier = cmd_word1[7:0];
		next_st.mine     = (cmd_word1[15:11] == own_area);
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '{go: 1'b0, func: IOC_F_MAINT, modifier: 8'h00, address: 16'h0000, mine: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign cmd.go       = st.go;
	assign cmd.func     = st.func;
	assign cmd.modifier = st.modifier;
	assign cmd.address  = st.address;
	assign cmd.mine     = st.mine;
endmodule

// ===== ioc_device.sv
`timescale 1ns/100ps
// device end of the execute command: decodes, runs one operation, keeps status
module ioc_device
	import ioc_pkg::*;
(
	// clock and reset
	input  wire logic        MCLK,
	input  wire logic        RST,
	// command from processor-controller
	input  wire logic        CMD_VALID,
	input  wire logic [15:0] CMD_WORD0,
	input  wire logic [15:0] CMD_WORD1,
	input  wire logic [4:0]  OWN_AREA,
	// accumulator load
	output logic             ACC_LOAD,
	output logic [15:0]      ACC_DATA,
	// direct program word transfer
	output logic             STORE_REQ,
	output logic             FETCH_REQ,
	output logic [15:0]      MEM_ADDR,
	output logic [15:0]      MEM_WDATA,
	input  wire logic        MEM_ACK,
	input  wire logic [15:0] MEM_RDATA,
	// data channel
	output logic             CHAN_START_WR,
	output logic             CHAN_START_RD,
	output logic [15:0]      CHAN_TABLE,
	input  wire logic        CHAN_TABLE_END,
	// device side
	input  wire logic [15:0] DEV_IN_WORD,
	output logic [15:0]      DEV_OUT_WORD,
	output logic             DEV_OUT_STB,
	output logic             CTRL_STB,
	output logic [7:0]       CTRL_MOD,
	output logic [15:0]      CTRL_ADDR,
	input  wire logic        DEV_ERROR,
	input  wire logic        OPER_REQ,
	input  wire logic        DEV_NOT_READY,
	// system side status sources
	input  wire logic [15:0] LEVEL_STATUS,
	input  wire logic [15:0] CONSOLE_STATUS,
	input  wire logic [15:0] TIMER_STATUS,
	// state out
	output logic             IRQ,
	output logic             MAINT_MODE,
	output logic             BUSY
);
	// ****************************************
	// decoder
	// ****************************************
	ioc_cmd_if cmd ();

	ioc_decode u_dec (
		.clk       (MCLK),
		.rst       (RST),
		.cmd_valid (CMD_VALID),
		.cmd_word0 (CMD_WORD0),
		.cmd_word1 (CMD_WORD1),
		.own_area  (OWN_AREA),
		.cmd       (cmd)
	);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		ioc_state_t  state;      // operation sequencer
		ioc_func_t   func;       // function in progress
		logic        acc_load;   // accumulator load pulse
		logic [15:0] acc_data;   // accumulator word
		logic        store_req;  // deliver word to storage
		logic        fetch_req;  // fetch word from storage
		logic [15:0] mem_addr;   // storage address
		logic [15:0] mem_wdata;  // word to store
		logic        ch_wr;      // channel write start pulse
		logic        ch_rd;      // channel read start pulse
		logic [15:0] ch_table;   // table start address
		logic [15:0] out_word;   // word to device
		logic        out_stb;    // device word strobe
		logic        ctrl_stb;   // control action strobe
		logic [7:0]  ctrl_mod;   // control modifier
		logic [15:0] ctrl_addr;  // control address
		logic        maint;      // maintenance mode
		logic        done;       // sticky operation complete
		logic        err;        // sticky error
		logic        oper;       // sticky operator request
		logic        irq;        // interrupt request
		logic        busy;       // operation in progress, drives the pin
	} ioc_dev_t;

	ioc_dev_t st;      // registered state
	ioc_dev_t next_st; // next state

	// error, operator and not-ready pin inputs pass two flops before use
	logic [2:0] sync1; // first stage, read only by second
	logic [2:0] sync2; // second stage
	logic       err_in;
	logic       oper_in;
	logic       nrdy_in;

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
		end else begin
			sync1 <= {DEV_ERROR, OPER_REQ, DEV_NOT_READY};
			sync2 <= sync1;
		end
	end

	assign err_in  = sync2[2];
	assign oper_in = sync2[1];
	assign nrdy_in = sync2[0];

	// builds the status word from current indicators
	function automatic logic [15:0] status_word(input ioc_dev_t s, input logic nrdy);
		logic [15:0] w;
		w = IOC_STATUS_RESET;
		w[IOC_ST_DONE]  = s.done;
		w[IOC_ST_ERROR] = s.err;
		w[IOC_ST_OPER]  = s.oper;
		w[IOC_ST_MAINT] = s.maint;
		w[IOC_ST_NRDY]  = nrdy | (s.state != IOC_S_IDLE);
		w[IOC_ST_BUSY]  = (s.state != IOC_S_IDLE);
		return w;
	endfunction

	// ****************************************
	// sequencer
	// ****************************************
	// command, transfer and status in one process
	always_comb begin
		logic busy_now;
		logic reset_sense;
		busy_now           = (st.state != IOC_S_IDLE);
		reset_sense        = 1'b0;
		next_st            = st;
		// pulses default low
		next_st.acc_load   = 1'b0;
		next_st.ch_wr      = 1'b0;
		next_st.ch_rd      = 1'b0;
		next_st.out_stb    = 1'b0;
		next_st.ctrl_stb   = 1'b0;

		unique case (st.state)
			IOC_S_IDLE: begin
				if (cmd.go && cmd.func == IOC_F_LEVEL) begin
					next_st.acc_data = LEVEL_STATUS;
					next_st.acc_load = 1'b1;
				end else if (cmd.go && cmd.mine) begin
					if (cmd.func == IOC_F_SENSE) begin
						if (OWN_AREA == IOC_AREA_CONSOLE) begin
							next_st.acc_data = (cmd.modifier == IOC_UNIT_TIMER) ? TIMER_STATUS
							                                                  : CONSOLE_STATUS;
						end else begin
							next_st.acc_data = status_word(st, nrdy_in);
						end
						next_st.acc_load = 1'b1;
						reset_sense      = cmd.modifier[IOC_MOD_RESET_BIT];
					end else if (!nrdy_in) begin
						next_st.func = cmd.func;
						unique case (cmd.func)
							IOC_F_MAINT: begin
								next_st.maint = cmd.modifier[IOC_MOD_RESET_BIT];
							end
							IOC_F_WRITE: begin
								next_st.fetch_req = 1'b1;
								next_st.mem_addr  = cmd.address;
								next_st.state     = IOC_S_PROG;
							end
							IOC_F_READ: begin
								next_st.store_req = 1'b1;
								next_st.mem_addr  = cmd.address;
								next_st.mem_wdata = DEV_IN_WORD;
								next_st.state     = IOC_S_PROG;
							end
							IOC_F_CONTROL: begin
								next_st.ctrl_stb  = 1'b1;
								next_st.ctrl_mod  = cmd.modifier;
								next_st.ctrl_addr = cmd.address;
								next_st.state     = IOC_S_DONE;
							end
							IOC_F_CH_WR: begin
								next_st.ch_wr    = 1'b1;
								next_st.acc_data = status_word(st, nrdy_in);
								next_st.acc_load = 1'b1;
								next_st.ch_table = cmd.address;
								next_st.state    = IOC_S_CHAN;
							end
							IOC_F_CH_RD: begin
								next_st.ch_rd    = 1'b1;
								next_st.acc_data = status_word(st, nrdy_in);
								next_st.acc_load = 1'b1;
								next_st.ch_table = cmd.address;
								next_st.state    = IOC_S_CHAN;
							end
							default: begin
								// level and sense handled above
								next_st.func = st.func;
							end
						endcase
					end
				end
			end
			IOC_S_PROG: begin
				if (MEM_ACK) begin
					next_st.fetch_req = 1'b0;
					next_st.store_req = 1'b0;
					if (st.fetch_req) begin
						next_st.out_word = MEM_RDATA;
						next_st.out_stb  = 1'b1;
						next_st.acc_data = MEM_RDATA;
					end else begin
						next_st.acc_data = st.mem_wdata;
					end
					next_st.acc_load = 1'b1;
					next_st.state    = IOC_S_DONE;
				end
			end
			IOC_S_CHAN: begin
				if (CHAN_TABLE_END) begin
					next_st.state = IOC_S_DONE;
				end
			end
			IOC_S_DONE: begin
				next_st.done  = 1'b1;
				next_st.state = IOC_S_IDLE;
			end
			default: begin
				next_st.state = IOC_S_IDLE;
			end
		endcase

		if (reset_sense) begin
			next_st.done = 1'b0;
			next_st.err  = 1'b0;
			next_st.oper = 1'b0;
		end
		if (st.state == IOC_S_DONE) begin
			next_st.done = 1'b1;
		end
		if (err_in) begin
			next_st.err = 1'b1;
		end
		if (oper_in) begin
			next_st.oper = 1'b1;
		end
		next_st.irq = next_st.done | next_st.err | next_st.oper;
		// busy kept in a flop so the pin has no decode behind it
		next_st.busy = (next_st.state != IOC_S_IDLE);
		// keep busy term read
		if (busy_now && next_st.state == IOC_S_IDLE) begin
			next_st.func = IOC_F_MAINT;
		end
	end

	// state register
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			st <= '{state: IOC_S_IDLE, func: IOC_F_MAINT, default: '0};
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// outputs straight from flops
	// ****************************************
	assign ACC_LOAD      = st.acc_load;
	assign ACC_DATA      = st.acc_data;
	assign STORE_REQ     = st.store_req;
	assign FETCH_REQ     = st.fetch_req;
	assign MEM_ADDR      = st.mem_addr;
	assign MEM_WDATA     = st.mem_wdata;
	assign CHAN_START_WR = st.ch_wr;
	assign CHAN_START_RD = st.ch_rd;
	assign CHAN_TABLE    = st.ch_table;
	assign DEV_OUT_WORD  = st.out_word;
	assign DEV_OUT_STB   = st.out_stb;
	assign CTRL_STB      = st.ctrl_stb;
	assign CTRL_MOD      = st.ctrl_mod;
	assign CTRL_ADDR     = st.ctrl_addr;
	assign IRQ           = st.irq;
	assign MAINT_MODE    = st.maint;
	assign BUSY          = st.busy;
endmodule

// ===== ioc_device_chk.sv
`timescale 1ns/100ps
// ****************************************
// port checker for the device end
// ****************************************
module ioc_device_chk
	import ioc_pkg::*;
(
	// clock and reset
	input wire logic        MCLK,
	input wire logic        RST,
	// command
	input wire logic        CMD_VALID,
	input wire logic [15:0] CMD_WORD1,
	input wire logic [4:0]  OWN_AREA,
	// results
	input wire logic        ACC_LOAD,
	input wire logic [15:0] ACC_DATA,
	input wire logic        FETCH_REQ,
	input wire logic        STORE_REQ,
	input wire logic [15:0] MEM_WDATA,
	input wire logic        MEM_ACK,
	input wire logic        DEV_OUT_STB,
	input wire logic        CHAN_START_WR,
	input wire logic        CHAN_START_RD,
	input wire logic        CHAN_TABLE_END,
	input wire logic        IRQ,
	input wire logic        MAINT_MODE,
	input wire logic        BUSY
);
	logic [3:0] since; // age of newest command, saturates
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	// saturating so an old command never looks recent
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			since <= 4'hf;
		else if (CMD_VALID)
			since <= 4'h0;
		else if (since != 4'hf)
			since <= since + 4'h1;
	end
	a_fetch_holds: assert property (FETCH_REQ && !MEM_ACK |=> FETCH_REQ) else $error("fetch dropped early");
	a_store_holds: assert property (STORE_REQ && !MEM_ACK |=> STORE_REQ && $stable(MEM_WDATA)) else $error("store moved");
	a_fetch_ends: assert property (FETCH_REQ && MEM_ACK |=> ACC_LOAD && DEV_OUT_STB && !FETCH_REQ) else $error("write end");
	a_store_acc: assert property (STORE_REQ && MEM_ACK |=> ACC_LOAD && ACC_DATA == $past(MEM_WDATA)) else $error("read acc");
	a_level_answer: assert property (CMD_VALID && CMD_WORD1[10:8] == 3'h3 && !BUSY |-> ##[1:3] ACC_LOAD) else $error("no level");
	a_maint_cause: assert property ($changed(MAINT_MODE) |-> since < 4'h5) else $error("maint changed alone");
	a_irq_sticky: assert property ($fell(IRQ) |-> since < 4'h5) else $error("irq cleared alone");
	a_chan_busy: assert property (CHAN_START_WR || CHAN_START_RD |=> BUSY) else $error("channel not busy");
	a_chan_end: assert property (BUSY && CHAN_TABLE_END |-> ##[1:3] !BUSY) else $error("channel not ended");
	a_area_ignore: assert property (CMD_VALID && !BUSY && CMD_WORD1[15:11] != OWN_AREA && CMD_WORD1[10:8] != 3'h3
		|=> (!ACC_LOAD && !FETCH_REQ && !STORE_REQ)[*4]) else $error("foreign area acted on");
	c_fetch: cover property (FETCH_REQ && MEM_ACK);
	c_chan_rd: cover property (CHAN_START_RD);
	c_irq_clear: cover property ($fell(IRQ));
endmodule

// ===== ioc_pc_model.sv
`timescale 1ns/100ps
// ****************************************
// processor side: storage and channel
// ****************************************
module ioc_pc_model
	import ioc_pkg::*;
(
	// clock and reset
	input wire logic        MCLK,
	input wire logic        RST,
	// pacing in cycles
	input wire logic [3:0]  LAT,
	// storage
	input wire logic        FETCH_REQ,
	input wire logic        STORE_REQ,
	input wire logic [15:0] MEM_ADDR,
	output logic            MEM_ACK,
	output logic [15:0]     MEM_RDATA,
	// channel
	input wire logic        CHAN_START_WR,
	input wire logic        CHAN_START_RD,
	output logic            CHAN_TABLE_END
);
	logic [3:0]  wait_cnt; // cycles a request waited
	logic [3:0]  chan_cnt; // table walk progress
	logic        chan_on;  // table walk running
	logic [15:0] noise;    // changes each cycle
	// data only means something with the ack
	assign MEM_RDATA = MEM_ACK ? ~MEM_ADDR : noise;
	// answer LAT+1 cycles after a request, end table LAT+2 cycles after start
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			{MEM_ACK, wait_cnt, chan_cnt, chan_on, CHAN_TABLE_END} <= '0;
			noise <= 16'h0000;
		end else begin
			noise <= noise + 16'h9e37;
			MEM_ACK <= 1'b0;
			CHAN_TABLE_END <= 1'b0;
			if ((FETCH_REQ || STORE_REQ) && !MEM_ACK) begin
				wait_cnt <= (wait_cnt == LAT) ? 4'h0 : wait_cnt + 4'h1;
				MEM_ACK <= (wait_cnt == LAT);
			end
			if (CHAN_START_WR || CHAN_START_RD) begin
				chan_on <= 1'b1;
				chan_cnt <= 4'h0;
			end else if (chan_on) begin
				chan_cnt <= chan_cnt + 4'h1;
				chan_on <= (chan_cnt != LAT);
				CHAN_TABLE_END <= (chan_cnt == LAT);
			end
		end
	end
endmodule

// ===== ioc_device_tb_top.sv
`timescale 1ns/100ps
// ****************************************
// command sequences against the device
// ****************************************
module ioc_device_tb_top;
	logic        MCLK = 1'b0, RST = 1'b1, CMD_VALID = 1'b0;
	logic [15:0] CMD_WORD0 = 16'h0000, CMD_WORD1 = 16'h0000, DEV_IN_WORD = 16'h0000;
	logic [4:0]  OWN_AREA = 5'h06;
	logic        DEV_ERROR = 1'b0, OPER_REQ = 1'b0, DEV_NOT_READY = 1'b0;
	logic [15:0] LEVEL_STATUS = 16'h8421, CONSOLE_STATUS = 16'h1357, TIMER_STATUS = 16'h2468;
	logic [3:0]  LAT = 4'h3;
	logic        ACC_LOAD, STORE_REQ, FETCH_REQ, MEM_ACK, CHAN_START_WR, CHAN_START_RD, CHAN_TABLE_END;
	logic        DEV_OUT_STB, CTRL_STB, IRQ, MAINT_MODE, BUSY;
	logic [15:0] ACC_DATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, CHAN_TABLE, DEV_OUT_WORD, CTRL_ADDR;
	logic [7:0]  CTRL_MOD;
	logic [15:0] acc, out_w, st_w, ch_t; // captured results
	logic [15:0] st_a;                   // storage address at the ack
	logic [1:0]  ch_k;                   // which channel start, read then write
	logic [23:0] ctl;                    // control modifier and address
	int          acc_n, ch_n, req_n, cyc, miscompares, cmp_count;
	always #20 MCLK = ~MCLK;
	ioc_device dut (.*);
	ioc_pc_model pc (.MCLK, .RST, .LAT, .FETCH_REQ, .STORE_REQ, .MEM_ADDR, .MEM_ACK, .MEM_RDATA,
		.CHAN_START_WR, .CHAN_START_RD, .CHAN_TABLE_END);
	// capture every one-cycle result in its own cycle
	always @(posedge MCLK) begin
		if (ACC_LOAD === 1'b1) begin
			acc <= ACC_DATA;
			acc_n <= acc_n + 1;
		end
		if (DEV_OUT_STB === 1'b1)
			out_w <= DEV_OUT_WORD;
		if (CTRL_STB === 1'b1)
			ctl <= {CTRL_MOD, CTRL_ADDR};
		if (CHAN_START_WR === 1'b1 || CHAN_START_RD === 1'b1) begin
			ch_t <= CHAN_TABLE;
			ch_k <= {CHAN_START_RD === 1'b1, CHAN_START_WR === 1'b1};
			ch_n <= ch_n + 1;
		end
		if (MEM_ACK === 1'b1) begin
			req_n <= req_n + 1;
			st_w <= MEM_WDATA;
			st_a <= MEM_ADDR;
		end
		cyc <= cyc + 1;
		// a hang is cut short here
		if (cyc == 20000) begin
			miscompares++;
			final_report();
		end
	end
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t bit %b expected %b", $time, got, exp);
		end
	endtask
	// one command, then wait out busy under a bound
	task automatic cmd(input logic [4:0] a, input logic [2:0] f, input logic [7:0] m, input logic [15:0] ad);
		int n = 0;
		CMD_VALID <= 1'b1;
		CMD_WORD0 <= ad;
		CMD_WORD1 <= {a, f, m};
		@(posedge MCLK);
		CMD_VALID <= 1'b0;
		repeat (3) @(posedge MCLK);
		while (BUSY !== 1'b0 && n < 300) begin
			@(posedge MCLK);
			n++;
		end
		chk_bit(n < 300, 1'b1);
		repeat (3) @(posedge MCLK);
	endtask
	task automatic sense(input logic r, input logic [15:0] exp);
		cmd(OWN_AREA, 3'h7, {r, 7'h00}, 16'hffff);
		chk_word(acc, exp);
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		{acc_n, ch_n, req_n, cyc, miscompares, cmp_count} = '0;
		repeat (20) @(posedge MCLK);
		RST <= 1'b0;
		@(posedge MCLK);
		sense(1'b0, 16'h0000);
		// single word out, then status held until a resetting sense
		cmd(OWN_AREA, 3'h1, 8'h00, 16'h1234);
		chk_word(out_w, 16'hedcb);
		chk_word(acc_n[15:0], 16'h0002);
		chk_bit(IRQ, 1'b1);
		sense(1'b0, 16'h0001);
		sense(1'b1, 16'h0001);
		sense(1'b0, 16'h0000);
		chk_bit(IRQ, 1'b0);
		// single word in, quick storage
		LAT <= 4'h0;
		DEV_IN_WORD <= 16'hbeef;
		cmd(OWN_AREA, 3'h2, 8'h00, 16'h0042);
		chk_word(st_w, 16'hbeef);
		chk_word(st_a, 16'h0042);
		chk_word(acc, 16'hbeef);
		sense(1'b1, 16'h0001);
		// level sense from a foreign area
		cmd(5'h1f, 3'h3, 8'h00, 16'h0000);
		chk_word(acc, 16'h8421);
		// maintenance mode leaves the accumulator alone
		cmd(OWN_AREA, 3'h0, 8'h80, 16'h0000);
		chk_bit(MAINT_MODE, 1'b1);
		chk_word(acc_n[15:0], 16'h0008);
		sense(1'b0, 16'h2000);
		cmd(OWN_AREA, 3'h0, 8'h00, 16'h0000);
		chk_bit(MAINT_MODE, 1'b0);
		// control carries modifier and address
		cmd(OWN_AREA, 3'h4, 8'h5a, 16'h0303);
		chk_word(ctl[23:8], 16'h5a03);
		chk_word(ctl[15:0], 16'h0303);
		sense(1'b1, 16'h0001);
		// both channel starts, slow table end
		LAT <= 4'h9;
		for (int f = 5; f <= 6; f++) begin
			cmd(OWN_AREA, f[2:0], 8'h00, 16'h0400 + f[15:0]);
			chk_word(ch_t, 16'h0400 + f[15:0]);
			chk_word(ch_n[15:0], f[15:0] - 16'h0004);
			chk_word({14'h0000, ch_k}, (f == 5) ? 16'h0001 : 16'h0002);
			chk_word(acc_n[15:0], f[15:0] * 16'h0002 + 16'h0001);
			sense(1'b1, 16'h0001);
		end
		// foreign area and not ready both refuse a write
		cmd(OWN_AREA ^ 5'h01, 3'h1, 8'h00, 16'h0010);
		chk_word(req_n[15:0], 16'h0002);
		DEV_NOT_READY <= 1'b1;
		repeat (4) @(posedge MCLK);
		cmd(OWN_AREA, 3'h1, 8'h00, 16'h0010);
		chk_word(req_n[15:0], 16'h0002);
		sense(1'b0, 16'h4000);
		DEV_NOT_READY <= 1'b0;
		// error and operator both interrupt
		DEV_ERROR <= 1'b1;
		OPER_REQ <= 1'b1;
		repeat (4) @(posedge MCLK);
		DEV_ERROR <= 1'b0;
		OPER_REQ <= 1'b0;
		repeat (4) @(posedge MCLK);
		chk_bit(IRQ, 1'b1);
		sense(1'b1, 16'h0006);
		sense(1'b0, 16'h0000);
		// area zero picks timer or console by unit
		OWN_AREA <= 5'h00;
		cmd(5'h00, 3'h7, 8'h01, 16'h0000);
		chk_word(acc, 16'h2468);
		cmd(5'h00, 3'h7, 8'h00, 16'h0000);
		chk_word(acc, 16'h1357);
		final_report();
	end
endmodule
bind ioc_device ioc_device_chk chk (.MCLK, .RST, .CMD_VALID, .CMD_WORD1, .OWN_AREA, .ACC_LOAD, .ACC_DATA,
	.FETCH_REQ, .STORE_REQ, .MEM_WDATA, .MEM_ACK, .DEV_OUT_STB, .CHAN_START_WR, .CHAN_START_RD,
	.CHAN_TABLE_END, .IRQ, .MAINT_MODE, .BUSY);
